/* pacs_pkg.sv */
package pacs_pkg;
    // wishbone word offsets (byte addresses)
    localparam logic [7:0] ADR_CFG_LO = 8'h00;
    localparam logic [7:0] ADR_CFG_HI = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;
    localparam logic [7:0] ADR_ID = 8'h0C;
    // arbitrary identification value
    localparam logic [31:0] ID_VALUE = 32'h0000A5C3;

    // configuration field positions
    localparam int TO_LSB = 7;
    localparam int TO_MSB = 8;
    localparam int WD_BIT = 6;
    localparam int CLK_LSB = 15;
    localparam int CLK_MSB = 16;
    localparam int FREEZE_BIT = 17;
    localparam int HDR_REC_BIT = 18;
    localparam int FLC_BIT = 19;
    localparam int HDR_LEN_BIT = 20;
    localparam int EXT_BIT = 21;
    localparam int HDR_LSB = 24;
    localparam int HDR_MSB = 39;
    localparam int FLEN_LSB = 40;
    localparam int FLEN_MSB = 47;
    localparam int LOW_BITS = 24;
    localparam int CFG_BITS = 48;

    // reset value: clock CLK_DIV4 code, hdr 9B58, len 08, time-out 1 s, watchdog on
    localparam logic [47:0] CFG_RESET = 48'h089B_5811_00C0;

    // output clock codes
    localparam logic [1:0] CLK_DIV1 = 2'h0;
    localparam logic [1:0] CLK_DIV2 = 2'h1;
    localparam logic [1:0] CLK_DIV4 = 2'h2;
    localparam logic [1:0] CLK_OFF = 2'h3;

    // time-out codes
    localparam logic [1:0] TO_OFF = 2'h0;
    localparam logic [1:0] TO_1S = 2'h1;
    localparam logic [1:0] TO_3S = 2'h2;

    // status bit positions
    localparam int ST_LOCK = 0;
    localparam int ST_TXEN = 1;
    localparam int ST_WDRST = 2;
    localparam int ST_RESET_OUT = 3;

    // timing
    localparam longint CLK_HZ = 125000000;
    localparam longint TO1_MS = 1000;
    localparam longint TO3_MS = 3000;
    localparam longint LOCK_MS = 125;
    localparam longint WD_MS = 1500;
    localparam longint RESET_OUT_MS = 10;
    localparam longint TO1_CYC = CLK_HZ / 1000 * TO1_MS;
    localparam longint TO3_CYC = CLK_HZ / 1000 * TO3_MS;
    localparam longint LOCK_CYC = CLK_HZ / 1000 * LOCK_MS;
    localparam longint WD_CYC = CLK_HZ / 1000 * WD_MS;
    localparam longint RESET_OUT_CYC = CLK_HZ / 1000 * RESET_OUT_MS;
endpackage

/* pacs_clkdiv.sv */
`timescale 1ns/100ps
// glitch-free divided master clock, output registered
module pacs_clkdiv (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic [1:0] sel_i,
    // clock out
    output logic mclk_o
);
    logic [2:0] cnt_q;
    logic [1:0] act_q;
    logic mclk_q;
    logic cyc_end;

    // a cycle ends at the last low phase of the running divider
    always_comb
    begin
        case (act_q)
            pacs_pkg::CLK_DIV1: cyc_end = cnt_q[0];
            pacs_pkg::CLK_DIV2: cyc_end = (cnt_q[1:0] == 2'h3);
            pacs_pkg::CLK_DIV4: cyc_end = (cnt_q == 3'h7);
            default: cyc_end = 1'b1;
        endcase
    end

    // selection switches only at end of the running cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            act_q <= pacs_pkg::CLK_DIV4;
        else if (cyc_end)
            act_q <= sel_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || cyc_end)
            cnt_q <= 3'h0;
        else
            cnt_q <= cnt_q + 3'h1;
    end

    // fastest registered rate is half the clock, codes 1 and 2 each halve it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mclk_q <= 1'b0;
        else
        begin
            case (act_q)
                pacs_pkg::CLK_DIV1: mclk_q <= ~cnt_q[0];
                pacs_pkg::CLK_DIV2: mclk_q <= ~cnt_q[1];
                pacs_pkg::CLK_DIV4: mclk_q <= ~cnt_q[2];
                default: mclk_q <= 1'b0;
            endcase
        end
    end

    assign mclk_o = mclk_q;
endmodule

/* pacs_supervisor.sv */
`timescale 1ns/100ps
// How it works
// - clock out at half, quarter, eighth of master clock rate
// - clock off code stops clock out
// - switch rate only at cycle end
// - upper 24 bits writable only when extended; bits 24-31 also by the write that sets it
// - frame count needs header recognition and extended
// - header held bits 24-39, default 9B58
// - frame length bits 40-47, default 08
// - receiving: flag high on in-band signal
// - band flag gated by carrier detect
// - flag is thermal during transmission
// - force receive after 1 or 3 s
// - transmit locked at least 125 ms
// - lock allows only registers and reception
// - both selects low at reset: lock
// - time-out length from bits 7-8
// - reset out low, released after delay
// - watchdog expiry resets, pulses reset out
module pacs_supervisor #(
    parameter longint TO1_CYC = pacs_pkg::TO1_CYC,
    parameter longint TO3_CYC = pacs_pkg::TO3_CYC,
    parameter longint LOCK_CYC = pacs_pkg::LOCK_CYC,
    parameter longint WD_CYC = pacs_pkg::WD_CYC,
    parameter longint RESET_OUT_CYC = pacs_pkg::RESET_OUT_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // host pins, asynchronous
    input wire logic tx_rx_select_i,
    input wire logic reg_data_select_i,
    input wire logic watchdog_kick_i,
    // analog status, asynchronous
    input wire logic band_detect_i,
    input wire logic carrier_detect_i,
    input wire logic thermal_i,
    // outputs
    output logic band_thermal_flag_o,
    output logic tx_enable_o,
    output logic reset_out_o,
    output logic mclk_o,
    output logic hdr_rec_en_o,
    output logic frame_count_en_o,
    output logic level_freeze_en_o,
    output logic hdr_len16_o,
    output logic [15:0] frame_header_o,
    output logic [7:0] frame_length_o
);
    logic [47:0] cfg_q;
    logic [4:0] s1_q;
    logic [4:0] s2_q;
    logic txrx_s;
    logic regd_s;
    logic wd_s;
    logic bu_s;
    logic cd_s;
    logic th_s;
    logic wd_prev_q;
    logic wd_rise;
    logic ack_q;
    logic [31:0] rdat_q;
    logic wr;
    logic rd;
    logic ext;
    logic [31:0] tx_cnt_q;
    logic [31:0] lock_cnt_q;
    logic [31:0] wd_cnt_q;
    logic [31:0] rst_cnt_q;
    logic lock_q;
    logic wd_exp;
    logic int_rst;
    logic strap_q;
    logic first_q;
    logic flag_q;
    logic txen_q;
    logic wdrst_q;

    typedef enum logic [1:0] {PACS_RUN, PACS_LOCK, PACS_WAIT_RX} pacs_lock_t;
    pacs_lock_t lk_q;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction

    function automatic logic [31:0] lim(input longint v);
        return (v < 1) ? 32'h0000_0001 : v[31:0];
    endfunction

    // pin synchronisers
    always_ff @(posedge clk_i)
    begin
        s1_q <= {tx_rx_select_i, reg_data_select_i, watchdog_kick_i, band_detect_i,
                 thermal_i};
        s2_q <= s1_q;
    end

    logic [1:0] cd_sync_q;
    always_ff @(posedge clk_i)
    begin
        cd_sync_q <= {cd_sync_q[0], carrier_detect_i};
    end

    assign txrx_s = s2_q[4];
    assign regd_s = s2_q[3];
    assign wd_s = s2_q[2];
    assign bu_s = s2_q[1];
    assign th_s = s2_q[0];
    assign cd_s = cd_sync_q[1];

    // internal reset: external or watchdog-generated
    assign int_rst = rst_i || wdrst_q;

    // wishbone slave, one wait state
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
    assign rd = wb_cyc_i && wb_stb_i && !ack_q;
    assign ext = cfg_q[pacs_pkg::EXT_BIT];

    // merged write words; unselected bytes keep their old value
    logic [31:0] lo_m;
    logic [31:0] hi_m;
    assign lo_m = merge(cfg_q[31:0], wb_dat_i, wb_sel_i);
    assign hi_m = merge({16'h0000, cfg_q[47:32]}, wb_dat_i, wb_sel_i);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_q <= 1'b0;
        else
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
    end

    always_ff @(posedge clk_i)
    begin
        if (int_rst)
            cfg_q <= pacs_pkg::CFG_RESET;
        else if (wr && wb_adr_i == pacs_pkg::ADR_CFG_LO)
        begin
            cfg_q[pacs_pkg::LOW_BITS-1:0] <= lo_m[pacs_pkg::LOW_BITS-1:0];
            if (ext || lo_m[pacs_pkg::EXT_BIT])
                cfg_q[31:24] <= lo_m[31:24];
        end
        else if (wr && wb_adr_i == pacs_pkg::ADR_CFG_HI && ext)
            cfg_q[47:32] <= hi_m[15:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdat_q <= 32'h0000_0000;
        else if (rd)
        begin
            case (wb_adr_i)
                pacs_pkg::ADR_CFG_LO: rdat_q <= cfg_q[31:0];
                pacs_pkg::ADR_CFG_HI: rdat_q <= {16'h0000, cfg_q[47:32]};
                pacs_pkg::ADR_STATUS: rdat_q <= {28'h0000000, reset_out_o, wdrst_q,
                                                  txen_q, lock_q};
                pacs_pkg::ADR_ID: rdat_q <= pacs_pkg::ID_VALUE;
                default: rdat_q <= 32'h0000_0000;
            endcase
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // decoded enables gated by the extended bit; header and length fields pass ungated
    assign level_freeze_en_o = ext && cfg_q[pacs_pkg::FREEZE_BIT];
    assign hdr_rec_en_o = ext && cfg_q[pacs_pkg::HDR_REC_BIT];
    assign frame_count_en_o = ext && cfg_q[pacs_pkg::HDR_REC_BIT]
                              && cfg_q[pacs_pkg::FLC_BIT];
    assign hdr_len16_o = ext ? cfg_q[pacs_pkg::HDR_LEN_BIT] : 1'b1;
    assign frame_header_o = cfg_q[pacs_pkg::HDR_MSB:pacs_pkg::HDR_LSB];
    assign frame_length_o = cfg_q[pacs_pkg::FLEN_MSB:pacs_pkg::FLEN_LSB];

    // shared flag: band in use in receive, thermal in transmit
    always_ff @(posedge clk_i)
    begin
        if (int_rst)
            flag_q <= 1'b0;
        else if (txen_q)
            flag_q <= th_s;
        else
            flag_q <= bu_s && cd_s;
    end
    assign band_thermal_flag_o = flag_q;

    // strap sampled in the first cycle after reset release
    always_ff @(posedge clk_i)
    begin
        if (int_rst)
            first_q <= 1'b1;
        else
            first_q <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (int_rst)
            strap_q <= 1'b0;
        // one-cycle pulse; transmit stays off until lock is entered
        else
            strap_q <= first_q && !txrx_s && !regd_s;
    end

    // continuous transmission counter
    always_ff @(posedge clk_i)
    begin
        if (int_rst || !txen_q)
            tx_cnt_q <= 32'h0000_0000;
        else
            tx_cnt_q <= tx_cnt_q + 32'h0000_0001;
    end

    logic to_hit;
    always_comb
    begin
        case (cfg_q[pacs_pkg::TO_MSB:pacs_pkg::TO_LSB])
            pacs_pkg::TO_1S: to_hit = (tx_cnt_q >= lim(TO1_CYC) - 32'h1);
            pacs_pkg::TO_3S: to_hit = (tx_cnt_q >= lim(TO3_CYC) - 32'h1);
            default: to_hit = 1'b0;
        endcase
    end

    // lockout machine
    always_ff @(posedge clk_i)
    begin
        if (int_rst)
        begin
            lk_q <= PACS_RUN;
            lock_cnt_q <= 32'h0000_0000;
        end
        else
        begin
            case (lk_q)
                PACS_RUN:
                begin
                    lock_cnt_q <= 32'h0000_0000;
                    if (strap_q || (txen_q && to_hit))
                        lk_q <= PACS_LOCK;
                end
                PACS_LOCK:
                begin
                    lock_cnt_q <= lock_cnt_q + 32'h0000_0001;
                    if (lock_cnt_q >= lim(LOCK_CYC) - 32'h1)
                        lk_q <= PACS_WAIT_RX;
                end
                PACS_WAIT_RX:
                begin
                    if (txrx_s)
                        lk_q <= PACS_RUN;
                end
                default: lk_q <= PACS_RUN;
            endcase
        end
    end
    assign lock_q = (lk_q != PACS_RUN);

    // transmit enable: host asks with select low, refused while locked
    always_ff @(posedge clk_i)
    begin
        if (int_rst)
            txen_q <= 1'b0;
        else
            txen_q <= !txrx_s && !lock_q && !(txen_q && to_hit)
                      && !first_q && !strap_q;
    end
    assign tx_enable_o = txen_q;

    // watchdog kick: rising end of a low pulse
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wd_prev_q <= 1'b1;
        else
            wd_prev_q <= wd_s;
    end
    assign wd_rise = wd_s && !wd_prev_q;

    always_ff @(posedge clk_i)
    begin
        if (int_rst || wd_rise)
            wd_cnt_q <= 32'h0000_0000;
        else if (cfg_q[pacs_pkg::WD_BIT] && !wd_exp)
            wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
    end
    // counter parks at expiry until the internal reset clears it
    assign wd_exp = (wd_cnt_q >= lim(WD_CYC) - 32'h1);

    // reset-out pulse generator, startup and watchdog
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rst_cnt_q <= 32'h0000_0000;
            wdrst_q <= 1'b0;
        end
        // expiry wins over release in the same cycle
        else if (wd_exp && !wdrst_q)
        begin
            rst_cnt_q <= 32'h0000_0000;
            wdrst_q <= 1'b1;
        end
        else if (rst_cnt_q < lim(RESET_OUT_CYC))
            rst_cnt_q <= rst_cnt_q + 32'h0000_0001;
        else
            wdrst_q <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            reset_out_o <= 1'b0;
        else
            reset_out_o <= (rst_cnt_q >= lim(RESET_OUT_CYC)) && !wdrst_q;
    end

    pacs_clkdiv u_clkdiv (
        .clk_i(clk_i),
        .rst_i(int_rst),
        .sel_i(cfg_q[pacs_pkg::CLK_MSB:pacs_pkg::CLK_LSB]),
        .mclk_o(mclk_o)
    );
endmodule

/* pacs_supervisor_properties.sv */
`timescale 1ns/100ps
module pacs_supervisor_properties #(
    parameter longint RESET_OUT_CYC = pacs_pkg::RESET_OUT_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // pins
    input wire logic tx_rx_select_i,
    input wire logic band_detect_i,
    input wire logic carrier_detect_i,
    input wire logic thermal_i,
    input wire logic band_thermal_flag_o,
    input wire logic tx_enable_o,
    input wire logic reset_out_o,
    // config
    input wire logic hdr_rec_en_o,
    input wire logic frame_count_en_o,
    input wire logic [15:0] frame_header_o,
    input wire logic [7:0] frame_length_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic [31:0] low_cnt_q;
    // cycles of reset out held low
    always_ff @(posedge clk_i)
    begin
        if (rst_i || reset_out_o)
            low_cnt_q <= 32'h0;
        else
            low_cnt_q <= low_cnt_q + 32'h1;
    end
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack after request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_flag_band: assert property ((!tx_enable_o && tx_rx_select_i && band_detect_i
        && carrier_detect_i && reset_out_o)[*5] |-> band_thermal_flag_o)
        else $error("band flag missing");
    chk_flag_gated: assert property ((!tx_enable_o && tx_rx_select_i
        && !carrier_detect_i)[*5] |-> !band_thermal_flag_o) else $error("flag not gated");
    chk_flag_thermal: assert property ((tx_enable_o && !tx_rx_select_i
        && $stable(thermal_i))[*5] |-> band_thermal_flag_o == thermal_i)
        else $error("flag not thermal in transmit");
    chk_tx_request: assert property ($rose(tx_enable_o)
        |-> !$past(tx_rx_select_i, 2) && !$past(tx_rx_select_i, 3))
        else $error("transmit without request");
    chk_rx_forced: assert property ($rose(tx_rx_select_i) |-> ##[1:4] !tx_enable_o)
        else $error("receive select ignored");
    chk_reset_out_width: assert property ($rose(reset_out_o) |-> low_cnt_q >= RESET_OUT_CYC - 1)
        else $error("reset out pulse short");
    chk_count_gate: assert property (frame_count_en_o |-> hdr_rec_en_o)
        else $error("frame count without header recognition");
    chk_reset_fields: assert property ($fell(rst_i)
        |-> frame_header_o == 16'h9B58 && frame_length_o == 8'h08)
        else $error("reset fields wrong");
    cover property ($fell(tx_enable_o) && !tx_rx_select_i);
    cover property ($fell(reset_out_o));
    cover property (frame_count_en_o);
endmodule

bind pacs_supervisor pacs_supervisor_properties #(.RESET_OUT_CYC(RESET_OUT_CYC)) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .tx_rx_select_i(tx_rx_select_i), .band_detect_i(band_detect_i),
    .carrier_detect_i(carrier_detect_i), .thermal_i(thermal_i),
    .band_thermal_flag_o(band_thermal_flag_o), .tx_enable_o(tx_enable_o),
    .reset_out_o(reset_out_o), .hdr_rec_en_o(hdr_rec_en_o),
    .frame_count_en_o(frame_count_en_o), .frame_header_o(frame_header_o),
    .frame_length_o(frame_length_o)
);

/* pacs_host.sv */
`timescale 1ns/100ps
module pacs_host (
    // clock
    input wire logic clk_i,
    // commands
    input wire logic want_tx_i,
    input wire logic data_mode_i,
    input wire logic kick_en_i,
    // pins
    output logic tx_rx_select_o,
    output logic reg_data_select_o,
    output logic watchdog_kick_o
);
    logic [5:0] cnt_q = 6'h00;
    logic on_q = 1'b0;
    // enable taken only at period start, so pulses stay whole
    always_ff @(posedge clk_i)
    begin
        cnt_q <= cnt_q + 6'h01;
        if (cnt_q == 6'h3F)
            on_q <= kick_en_i;
    end
    assign tx_rx_select_o = !want_tx_i;
    assign reg_data_select_o = data_mode_i;
    assign watchdog_kick_o = !(on_q && cnt_q < 6'h04);
endmodule

/* test_pacs_supervisor.sv */
`timescale 1ns/100ps
module test_pacs_supervisor;
    localparam longint TO1 = 200;
    localparam longint TO3 = 400;
    localparam longint LCK = 50;
    localparam longint WD = 300;
    localparam longint RST = 20;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic want_tx = 1'b1;
    logic data_mode = 1'b0;
    logic kick_en = 1'b0;
    logic band = 1'b0;
    logic carr = 1'b0;
    logic therm = 1'b0;
    logic txrx, rdsel, kick, ack, flag, txen, reset_out, mclk, hrec, fcnt, frz, h16;
    logic [31:0] rdat;
    logic [15:0] hdr;
    logic [7:0] flen;
    logic [31:0] q;
    logic [31:0] r;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    int rises = 0;
    int n;

    always #4 clk_i = ~clk_i;
    always @(posedge mclk) rises++;

    pacs_host u_host (
        .clk_i(clk_i), .want_tx_i(want_tx), .data_mode_i(data_mode), .kick_en_i(kick_en),
        .tx_rx_select_o(txrx), .reg_data_select_o(rdsel), .watchdog_kick_o(kick)
    );
    pacs_supervisor #(
        .TO1_CYC(TO1), .TO3_CYC(TO3), .LOCK_CYC(LCK), .WD_CYC(WD), .RESET_OUT_CYC(RST)
    ) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .tx_rx_select_i(txrx), .reg_data_select_i(rdsel), .watchdog_kick_i(kick),
        .band_detect_i(band), .carrier_detect_i(carr), .thermal_i(therm),
        .band_thermal_flag_o(flag), .tx_enable_o(txen), .reset_out_o(reset_out), .mclk_o(mclk),
        .hdr_rec_en_o(hrec), .frame_count_en_o(fcnt), .level_freeze_en_o(frz),
        .hdr_len16_o(h16), .frame_header_o(hdr), .frame_length_o(flen)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        q = rdat;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic complete_run;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic logic [31:0] mclk_rises(input logic [1:0] code);
        return (code == pacs_pkg::CLK_OFF) ? 32'h0 : 32'h20 >> code;
    endfunction

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            complete_run();
        end
    end

    initial
    begin
        r = $urandom(23439);
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("reset_out_low", reset_out, 0);
        repeat (10) @(posedge clk_i);
        check("strap_lock", txen, 0);
        want_tx <= 1'b0;
        data_mode <= 1'b1;
        repeat (LCK + 10) @(posedge clk_i);
        check("reset_out_high", reset_out, 1);
        want_tx <= 1'b1;
        repeat (6) @(posedge clk_i);
        check("unlock", txen, 1);
        want_tx <= 1'b0;
        check("hdr", hdr, 16'h9B58);
        check("flen", flen, 8'h08);
        bus(1'b1, pacs_pkg::ADR_CFG_HI, 32'h0000_1234);
        bus(1'b0, pacs_pkg::ADR_CFG_HI, 32'h0);
        check("hi_short", q, 32'h0000_089B);
        bus(1'b0, 8'h10, 32'h0);
        check("unmapped", q, 32'h0);
        bus(1'b0, pacs_pkg::ADR_ID, 32'h0);
        check("id", q, pacs_pkg::ID_VALUE);
        r = $urandom;
        r[8] = 1'b1;
        bus(1'b1, pacs_pkg::ADR_CFG_LO, {r[31:24], 24'h3E_0000});
        bus(1'b1, pacs_pkg::ADR_CFG_HI, {16'h0, r[15:0]});
        bus(1'b0, pacs_pkg::ADR_CFG_HI, 32'h0);
        check("cfg_hi", q, {16'h0, r[15:0]});
        check("hdr_rw", hdr, {r[7:0], r[31:24]});
        check("flen_rw", flen, r[15:8]);
        check("hdr16", h16, 1);
        for (int k = 0; k < 4; k++)
        begin
            bus(1'b1, pacs_pkg::ADR_CFG_LO, 32'h000A_0000 | {10'h0, k[1], 2'b0, k[0], 18'h0});
            check("hdr_rec", hrec, k[0] & k[1]);
            check("frame_cnt", fcnt, k[0] & k[1]);
            check("freeze", frz, k[1]);
        end
        for (int k = 0; k < 4; k++)
        begin
            bus(1'b1, pacs_pkg::ADR_CFG_LO, {15'h0, k[1:0], 15'h0});
            repeat (16) @(posedge clk_i);
            rises = 0;
            repeat (64) @(posedge clk_i);
            check("mclk_rate", rises, mclk_rises(k[1:0]));
        end
        repeat (24)
        begin
            r = $urandom;
            want_tx <= r[0];
            band <= r[1];
            carr <= r[2];
            therm <= r[3];
            repeat (8) @(posedge clk_i);
            check("tx_en", txen, r[0]);
            check("flag", flag, r[0] ? r[3] : r[1] & r[2]);
        end
        want_tx <= 1'b0;
        for (int k = 1; k < 3; k++)
        begin
            bus(1'b1, pacs_pkg::ADR_CFG_LO, {23'h0, k[1:0], 7'h0});
            want_tx <= 1'b1;
            repeat (k == 1 ? TO1 - 10 : TO3 - 10) @(posedge clk_i);
            check("tx_before", txen, 1);
            repeat (20) @(posedge clk_i);
            check("tx_timeout", txen, 0);
            bus(1'b0, pacs_pkg::ADR_CFG_LO, 32'h0);
            check("reg_in_lock", q, {23'h0, k[1:0], 7'h0});
            bus(1'b0, pacs_pkg::ADR_STATUS, 32'h0);
            check("status_lock", q, 32'h0000_0009);
            want_tx <= 1'b0;
            repeat (6) @(posedge clk_i);
            want_tx <= 1'b1;
            repeat (LCK - 40) @(posedge clk_i);
            check("tx_locked", txen, 0);
            want_tx <= 1'b0;
            repeat (LCK) @(posedge clk_i);
            want_tx <= 1'b1;
            repeat (6) @(posedge clk_i);
            check("tx_again", txen, 1);
            want_tx <= 1'b0;
            repeat (6) @(posedge clk_i);
        end
        kick_en <= 1'b1;
        bus(1'b1, pacs_pkg::ADR_CFG_LO, 32'h0000_0040);
        repeat (3 * WD) @(posedge clk_i);
        check("wd_kicked", reset_out, 1);
        kick_en <= 1'b0;
        n = 0;
        while (reset_out === 1'b1 && n < WD + 100)
        begin
            @(posedge clk_i);
            n++;
        end
        check("wd_fired", reset_out, 0);
        repeat (2) @(posedge clk_i);
        check("wd_reload", flen, 8'h08);
        repeat (RST + 10) @(posedge clk_i);
        check("wd_release", reset_out, 1);
        complete_run();
    end
endmodule
